// *** host_board_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host board pins and power stage stand-in
module host_board_model #(
  parameter int RAMP = 10  // Cycles for rails to settle
) (
  input  wire logic sys_clk,   // Clock
  input  wire logic on_pull,   // Host pulls request low
  input  wire logic kill_pull, // Host pulls shutoff low
  input  wire logic sag,       // Forced rail sag
  input  wire logic rail_en,   // Converter enable
  output logic      on_pin,    // Request pin level
  output logic      kill_pin,  // Shutoff pin level
  output logic      rails_ok,  // Rails regulated
  output logic      wp_pin     // Store write-protect level
);
  int cnt;
  // Open-drain host drivers; the unit's pull-up wins once released
  assign on_pin   = on_pull ? 1'b0 : 1'b1;
  assign kill_pin = kill_pull ? 1'b0 : 1'b1;
  // Host board keeps the store's write-protect low at all times
  assign wp_pin   = 1'b0;
  // Rails settle after a ramp and collapse at once on disable
  always_ff @(posedge sys_clk) begin
    cnt <= rail_en ? ((cnt < RAMP) ? cnt + 1 : cnt) : 0;
  end
  assign rails_ok = (cnt == RAMP) && !sag;
endmodule
`default_nettype wire

// *** psu_control_status_signals.sv ***
// Function
// - Names ending _n are asserted low
// - Mains good high within 90-264 VAC
// - Alert on warn, fail, OC, OV, fan
// - Alert idles high, low means alert
// - Amber LED changes with alert
// - Management bus runs at 100 kHz
// - Shutoff low enables main output
// - On request low turns main rail on
// - On request pulled inactive when undriven
// - Power good only when all regulated
// - Power good drops on undervolt or holdup
// - Current limit holds off good delay
// - Power good is open-drain
// - Slot address high reads as one
// - Installed pin tied low through resistor
// - Power good 100-500 ms after regulation
// - Power good drops within 5 ms
// - Rail regulated 5-400 ms after request
// - Overvoltage latches off until toggle
`timescale 1ns/1ps
`default_nettype none
`include "psu_sig_map.svh"
module psu_control_status_signals
  import psu_sig_pkg::*;
#(
  parameter int PGOOD_DLY_MS = 200,  // Chosen power-good delay within window
  parameter int PGOOD_DLY    = PGOOD_DLY_MS * `CLK_KHZ,
  parameter int RAMP_TO      = `RAIL_ON_MAX_MS * `CLK_KHZ
) (
  input  wire logic                    sys_clk,             // 25 MHz clock
  input  wire logic                    rst_n,               // Sync reset, low
  input  wire logic                    output_on_request_n, // Host on request pin
  input  wire logic                    hot_swap_shutoff_n,  // Host shutoff pin
  input  wire logic                    slot_addr_bit0,      // Slot address pin 0
  input  wire logic                    slot_addr_bit1,      // Slot address pin 1
  input  wire logic                    mains_in_range,      // Input in 90-264 VAC
  input  wire logic                    mains_holdup_lost,   // Input loss beyond holdup
  input  wire logic                    rails_in_reg,        // All outputs regulated
  input  wire logic                    in_curr_limit,       // Any output current-limited
  input  wire health_s                 health,              // Fault monitors
  output logic                         main_rail_en,        // Main converter enable
  output logic                         mains_good,          // Mains good output
  output logic                         fault_alert,         // Alert, low active
  output logic                         led_amber,           // Amber status LED
  output logic                         output_power_good_oe,// Power good pull-low
  output logic                         output_power_good,   // Power good level
  output logic [`SLOT_ADDR_W-1:0]      mgmt_addr,           // Bus address bits
  output logic                         unit_installed_n,    // Presence, tied low
  output logic                         mgmt_clk_en          // 100 kHz bus tick
);
  localparam int BUS_DIV = `CLK_KHZ / `MGMT_BUS_KHZ;
  localparam int MIN_DLY = `PGOOD_ON_MIN_MS * `CLK_KHZ;
  localparam int MAX_DLY = `PGOOD_ON_MAX_MS * `CLK_KHZ;
  // Elaboration checks: counters and divider must be able to serve the values
  if (PGOOD_DLY < 1 || RAMP_TO < 1) begin : g_bad_delay
    $error("Delays must be positive");
  end
  if (PGOOD_DLY_MS * `CLK_KHZ < MIN_DLY || PGOOD_DLY_MS * `CLK_KHZ > MAX_DLY) begin : g_bad_win
    $error("Power-good delay outside its window");
  end
  if (BUS_DIV < 2 || BUS_DIV > 65536) begin : g_bad_div
    $error("Bus divider does not fit its counter");
  end

  // ==========================================================
  // Input synchronisers
  // Host pins are asynchronous; two stages before any use
  logic [3:0] meta_r, sync_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= `SYNC_IDLE;  // Idle: request and shutoff released
      sync_r <= `SYNC_IDLE;
    end else begin
      meta_r <= {output_on_request_n, hot_swap_shutoff_n, slot_addr_bit1, slot_addr_bit0};
      sync_r <= meta_r;
    end
  end
  wire on_req  = ~sync_r[3];
  wire enable  = ~sync_r[2];
  wire run_req = on_req & enable;

  // ==========================================================
  // Overvoltage latch, cleared by request toggle or input loss
  logic ov_latch_r, on_req_d_r;
  wire  req_rise = on_req & ~on_req_d_r;
  // A trip in the same cycle as a clear wins, so no fault slips through
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ov_latch_r <= 1'b0;
      on_req_d_r <= 1'b0;
    end else begin
      on_req_d_r <= on_req;
      if (health.over_volt) ov_latch_r <= 1'b1;
      else if (!on_req || mains_holdup_lost) ov_latch_r <= 1'b0;
    end
  end

  // ==========================================================
  // Sequencer
  seq_e        st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  wire  go = run_req & ~ov_latch_r & ~health.over_volt & mains_in_range;
  // Any sag during the delay restarts the full hold-off from the ramp state
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r + 32'h1;
    case (st_r)
      ST_OFF: begin
        cnt_nxt = 32'h0;
        if (go) st_nxt = ST_RAMP;
      end
      ST_RAMP: begin
        if (rails_in_reg) begin
          st_nxt  = ST_DELAY;
          cnt_nxt = 32'h0;
        end
      end
      ST_DELAY: begin
        if (in_curr_limit) cnt_nxt = 32'h0;
        else if (cnt_r >= 32'(PGOOD_DLY - 1)) st_nxt = ST_GOOD;
        if (!rails_in_reg) begin
          st_nxt  = ST_RAMP;
          cnt_nxt = 32'h0;
        end
      end
      ST_GOOD: if (!rails_in_reg || mains_holdup_lost) st_nxt = ST_RAMP;
      default: st_nxt = ST_OFF;
    endcase
    if (!go) st_nxt = ST_OFF;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r  <= ST_OFF;
      cnt_r <= 32'h0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Indications, all registered except the tied-low presence pin
  wire alert_any = |health;
  logic good_r, mains_r, alert_r, en_r;
  logic [`SLOT_ADDR_W-1:0] addr_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      good_r  <= 1'b0;
      mains_r <= 1'b0;
      alert_r <= 1'b0;
      en_r    <= 1'b0;
      addr_r  <= '0;
    end else begin
      good_r  <= (st_nxt == ST_GOOD);
      mains_r <= mains_in_range;
      alert_r <= alert_any;
      en_r    <= (st_nxt != ST_OFF);
      addr_r  <= sync_r[1:0];
    end
  end
  assign main_rail_en         = en_r;
  assign mains_good           = mains_r;
  assign fault_alert          = ~alert_r;
  assign led_amber            = alert_r;
  assign output_power_good    = good_r;
  assign output_power_good_oe = ~good_r;       // Pull low when not good
  assign mgmt_addr            = addr_r;
  assign unit_installed_n     = 1'b0;

  // ==========================================================
  // Management bus tick; protocol engine lives elsewhere
  logic [15:0] div_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) div_r <= 16'h0;
    else if (div_r == 16'(BUS_DIV - 1)) div_r <= 16'h0;
    else div_r <= div_r + 16'h1;
  end
  assign mgmt_clk_en = (div_r == 16'(BUS_DIV - 1));

  // ==========================================================
  // Checks
  // Pin and LED share one flop; a split here means a wiring slip
  a_alert_led: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fault_alert == ~led_amber) else $error("Alert and LED disagree");
  a_alert_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    alert_any |=> !fault_alert) else $error("Alert missing");
  a_alert_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !alert_any |=> fault_alert) else $error("Alert without cause");
  a_good_reg: assert property (@(posedge sys_clk) disable iff (!rst_n)
    output_power_good |-> $past(rails_in_reg)) else $error("Good while out of reg");
  a_good_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !on_req |=> !output_power_good) else $error("Good not dropped");
  // The count is read one cycle back, where the move to good was decided
  a_good_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(output_power_good) |->
      $past(st_r) == ST_DELAY && $past(cnt_r) >= 32'(PGOOD_DLY - 1))
    else $error("Good without delay");
  a_kill_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !enable |=> !main_rail_en) else $error("Rail on while shut off");
  a_rail_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !on_req |=> !main_rail_en) else $error("Rail on without request");
  a_ov_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    health.over_volt |=> ov_latch_r && !main_rail_en) else $error("No OV latch");
  a_ov_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ov_latch_r && on_req && !mains_holdup_lost |=> ov_latch_r) else $error("OV latch let go");
  a_mains: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mains_in_range |=> mains_good) else $error("Mains good wrong");
  a_mains_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !mains_in_range |=> !mains_good) else $error("Mains good stuck high");
  a_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mgmt_addr == $past(sync_r[1:0])) else $error("Address wrong");
  a_clim_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r == ST_DELAY && in_curr_limit && go && rails_in_reg) |=> cnt_r == 32'h0)
    else $error("Delay ran in current limit");
  // Main scenarios: turn-on, trip, alert, request toggle, held-off delay
  c_turn_on:  cover property (@(posedge sys_clk) $rose(output_power_good));
  c_ov_trip:  cover property (@(posedge sys_clk) $rose(ov_latch_r));
  c_alert:    cover property (@(posedge sys_clk) $fell(fault_alert));
  c_re_req:   cover property (@(posedge sys_clk) req_rise);
  c_clim:     cover property (@(posedge sys_clk) st_r == ST_DELAY && in_curr_limit);
endmodule
`default_nettype wire

// *** psu_control_status_signals_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psu_sig_map.svh"
module psu_control_status_signals_test;
  import psu_sig_pkg::*;
  localparam int PG = 20;
  logic sys_clk, rst_n, onp, killp, sag, mir, hl, cl, a0, a1, rok, onpin, kpin;
  logic en, mg, al, amb, oe, pg, inst_n, tk, wp;
  logic [1:0] addr;
  health_s h;
  int n_fail, num_checks, cyc, n;
  // ==========
  // Clock and hang guard
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  psu_control_status_signals #(.PGOOD_DLY(PG)) psu_control_status_signals_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .output_on_request_n(onpin),
    .hot_swap_shutoff_n(kpin), .slot_addr_bit0(a0), .slot_addr_bit1(a1),
    .mains_in_range(mir), .mains_holdup_lost(hl), .rails_in_reg(rok),
    .in_curr_limit(cl), .health(h), .main_rail_en(en), .mains_good(mg),
    .fault_alert(al), .led_amber(amb), .output_power_good_oe(oe),
    .output_power_good(pg), .mgmt_addr(addr), .unit_installed_n(inst_n),
    .mgmt_clk_en(tk));
  host_board_model host_board_model_inst (.sys_clk(sys_clk), .on_pull(onp),
    .kill_pull(killp), .sag(sag), .rail_en(en), .on_pin(onpin),
    .kill_pin(kpin), .rails_ok(rok), .wp_pin(wp));
  // ==========
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycles until power good, capped so a dead output cannot hang us
  task automatic wait_good(output int c);
    c = 0;
    while (pg !== 1'b1 && c < 200) begin
      tick(1);
      c++;
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    {rst_n, onp, killp, sag, mir, hl, cl, a0, a1} = 9'h002;
    h = '0;
    void'($urandom(99));
    tick(16);
    rst_n = 1;
    chk({en, pg, oe, al, amb, mg, addr, inst_n}, 16'h0060);
    chk(wp, 1'b0);
    // Every fault source and address, then random mixes
    for (int i = 0; i < 16; i++) begin
      h = (i < 6) ? health_s'(6'h01 << i) : health_s'(6'($urandom));
      {a1, a0} = (i < 4) ? i[1:0] : 2'($urandom);
      mir = 1'($urandom);
      tick(5);
      chk(al, ~|h);
      chk(amb, |h);
      chk(addr, {a1, a0});
      chk(mg, mir);
    end
    h = '0;
    // Turn-on with current limit holding off the good delay; mains in range
    // and the shutoff pulled low are needed as well
    mir = 1;
    killp = 1;
    onp = 1;
    cl = 1;
    tick(6);
    chk(en, 1'b1);
    tick(60);
    chk(pg, 1'b0);
    cl = 0;
    wait_good(n);
    chk(n >= PG && n <= PG + 6, 1'b1);
    chk({pg, oe}, 2'b10);
    sag = 1;
    tick(4);
    chk(pg, 1'b0);
    sag = 0;
    wait_good(n);
    chk(n >= PG && n <= PG + 6, 1'b1);
    hl = 1;
    tick(4);
    chk(pg, 1'b0);
    hl = 0;
    killp = 0;
    tick(6);
    chk(en, 1'b0);
    killp = 1;
    tick(6);
    chk(en, 1'b1);
    h.over_volt = 1;
    tick(4);
    chk(en, 1'b0);
    h = '0;
    tick(10);
    chk(en, 1'b0);
    onp = 0;
    tick(6);
    chk({en, pg}, 2'b00);
    onp = 1;
    tick(6);
    chk(en, 1'b1);
    // Bus tick spacing
    while (tk !== 1'b1) tick(1);
    n = 0;
    tick(1);
    while (tk !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(n + 1), 16'(`CLK_KHZ / `MGMT_BUS_KHZ));
    conclude();
  end
endmodule
`default_nettype wire

// *** psu_sig_map.svh ***
`ifndef PSU_SIG_MAP_SVH
`define PSU_SIG_MAP_SVH
// Clock rate in kHz (25 MHz)
`define CLK_KHZ          25000
// Power-good assertion window after regulation, ms
`define PGOOD_ON_MIN_MS  100
`define PGOOD_ON_MAX_MS  500
// Power-good drop after on request released, ms (longest)
`define PGOOD_OFF_MAX_MS 5
// Rail regulation window after on request, ms
`define RAIL_ON_MIN_MS   5
`define RAIL_ON_MAX_MS   400
// Management bus clock, kHz
`define MGMT_BUS_KHZ     100
// Address field width
`define SLOT_ADDR_W      2
// Synchroniser idle word {request, shutoff, addr1, addr0}: both pins released high
`define SYNC_IDLE        4'hc
`endif

// *** psu_sig_pkg.sv ***
`default_nettype none
package psu_sig_pkg;
  // Sequencer states
  typedef enum logic [1:0] {ST_OFF, ST_RAMP, ST_DELAY, ST_GOOD} seq_e;
  // Health inputs from the power stage and monitors
  typedef struct packed {
    logic temp_warn;    // Temperature warning
    logic gen_fail;     // General failure
    logic over_curr;    // Overcurrent
    logic over_volt;    // Overvoltage
    logic fan_fail;     // Fan failed
    logic other_event;  // Other critical or warning event
  } health_s;
endpackage
`default_nettype wire
